/* File: design/scg_top.sv */
// Purpose: Configuration word one, protection decode and access gating
// Assumes: APB register port on clk_in; masters present one access per request
// Notes:   Outputs all registered; refused accesses answer with error
`timescale 1ns/1ps
module scg_top #(
  parameter int NPORT = scg_pkg::NPORT
) (
  input  wire logic             clk_in,            // 10 MHz clock
  input  wire logic             nrst_in,           // Sync reset, active low
  input  wire logic             psel_in,           // Register select
  input  wire logic             penable_in,        // Access phase
  input  wire logic             pwrite_in,         // Write
  input  wire logic             pprot1_in,         // 1 = non-secure
  input  wire logic [11:0]      paddr_in,          // Byte address
  input  wire logic [31:0]      pwdata_in,         // Write data
  input  wire logic             cfg_one_pb0_in,    // PLL b divider bit 0 level
  input  wire logic             req_in,            // Peripheral access request
  input  wire logic             req_nsec_in,       // Request is non-secure
  input  wire logic             req_ext_in,        // Request from external master
  input  wire logic [NPORT-1:0] req_sel0_in,       // One-hot APB target
  input  wire logic [NPORT-1:0] req_sel1_in,       // One-hot AXI target
  input  wire logic             filt_wr_in,        // Filter config write request
  input  wire logic [11:0]      filt_addr_in,      // Filter config offset
  output logic [31:0]           prdata_out,        // Read data
  output logic                  pready_out,        // Access done
  output logic                  pslverr_out,       // Error answer
  output logic                  req_pass_out,      // Access forwarded, pulse
  output logic                  req_err_out,       // Access refused, pulse
  output logic                  req_nsec_out,      // Forwarded security attribute
  output logic                  filt_wr_out,       // Filter write takes effect, pulse
  output logic [3:0]            cluster_number_out, // Cluster number
  output logic                  l2_big_endian_select_out, // Cache endianness
  output logic                  l2_cache_enable_out,      // Cache present
  output logic                  secure_invasive_debug_en_out, // Secure debug
  output logic                  noninvasive_debug_en_out,     // Non-invasive debug
  output logic                  invasive_debug_en_out,        // Invasive debug
  output logic [3:0]            memclk_pll_c_divider_out,     // PLL c divider
  output logic [3:0]            memclk_pll_b_divider_out,     // PLL b divider
  output logic                  filter_active_out,            // Space filter enabled
  output logic [NPORT-1:0]      dec0_out,          // Decode word 0
  output logic [NPORT-1:0]      dec1_out,          // Decode word 1
  output logic                  ext_force_nsec_out, // External override
  output logic                  trace_control_pin_out // Always low
);

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  logic pb0_s1_reg, pb0_s2_reg;
  always_ff @(posedge clk_in) begin
    pb0_s1_reg <= cfg_one_pb0_in;
    pb0_s2_reg <= pb0_s1_reg;
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0]      cfg_reg, cfg_next;
  logic [NPORT-1:0] d0_reg, d0_next, d1_reg, d1_next;
  logic             d2_reg, d2_next;
  logic [31:0]      rd_reg, rd_next;
  logic             rdy_reg, rdy_next, err_reg, err_next;
  logic             wr_go, hit_cfg1, hit_cfg2, hit_d0, hit_d1, hit_d2, ns;

  assign wr_go    = psel_in & penable_in & pwrite_in & ~rdy_reg;
  assign ns       = pprot1_in;
  assign hit_cfg1 = (paddr_in == scg_pkg::OFF_CFG_ONE);
  assign hit_cfg2 = (paddr_in == scg_pkg::OFF_CFG_TWO);
  assign hit_d0   = (paddr_in == scg_pkg::OFF_DEC0);
  assign hit_d1   = (paddr_in == scg_pkg::OFF_DEC1);
  assign hit_d2   = (paddr_in == scg_pkg::OFF_DEC2);

  always_comb begin
    logic hit_any;
    hit_any  = hit_cfg1 | hit_cfg2 | hit_d0 | hit_d1 | hit_d2;
    cfg_next = cfg_reg;
    d0_next  = d0_reg;
    d1_next  = d1_reg;
    d2_next  = d2_reg;
    rd_next  = '0;
    rdy_next = psel_in & penable_in & ~rdy_reg;
    err_next = 1'b0;
    if (wr_go) begin
      if (hit_cfg1) begin
        // Masked write keeps read-only bits
        cfg_next = (pwdata_in & scg_pkg::CFG_ONE_WMASK)
                 | (cfg_reg & ~scg_pkg::CFG_ONE_WMASK);
      end else if ((hit_d0 | hit_d1 | hit_d2) && !ns) begin
        // Only secure writes change decode bits
        if (hit_d0) d0_next = pwdata_in[NPORT-1:0] & scg_pkg::DEC0_USED;
        if (hit_d1) d1_next = pwdata_in[NPORT-1:0] & scg_pkg::DEC1_USED;
        if (hit_d2) d2_next = pwdata_in[0];
      end else if (!hit_any) begin
        err_next = 1'b1; // Writes to unused words fail
      end
    end else if (psel_in && penable_in && !rdy_reg) begin
      if (hit_cfg1) begin
        // Read-only bits read back their value; only reserved bits give zero
        rd_next = cfg_reg & ~scg_pkg::CFG_ONE_RSVD;
      end else if (hit_cfg2) begin
        rd_next = scg_pkg::CFG_TWO_RESET & scg_pkg::CFG_TWO_WMASK;
      end else if (!ns) begin
        if (hit_d0) rd_next = {16'h0000, d0_reg};
        if (hit_d1) rd_next = {16'h0000, d1_reg};
        if (hit_d2) rd_next = {31'h0000_0000, d2_reg};
      end
      // Unused words and non-secure decode reads give zero
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cfg_reg <= scg_pkg::CFG_ONE_RESET;
      d0_reg  <= scg_pkg::DEC_RESET;
      d1_reg  <= scg_pkg::DEC_RESET;
      d2_reg  <= 1'b0;
      rd_reg  <= '0;
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      d0_reg  <= d0_next;
      d1_reg  <= d1_next;
      d2_reg  <= d2_next;
      rd_reg  <= rd_next;
      rdy_reg <= rdy_next;
      err_reg <= err_next;
    end
  end

  // ----------------------------------------------------------------
  // Access gating
  // ----------------------------------------------------------------
  logic allow0, allow1, eff_nsec;
  logic pass_reg, pass_next, rej_reg, rej_next, rnsec_reg, rnsec_next;
  logic fw_reg, fw_next;
  scg_pkg::scg_state_e st_reg, st_next;

  // External override forces non-secure
  assign eff_nsec = req_nsec_in | (req_ext_in & d2_reg);

  scg_gate #(.N(NPORT)) u_gate0 (
    .open_in   (d0_reg),
    .sel_in    (req_sel0_in),
    .nsec_in   (eff_nsec),
    .allow_out (allow0)
  );
  scg_gate #(.N(NPORT)) u_gate1 (
    .open_in   (d1_reg),
    .sel_in    (req_sel1_in),
    .nsec_in   (eff_nsec),
    .allow_out (allow1)
  );

  always_comb begin
    st_next    = scg_pkg::SCG_IDLE;
    pass_next  = 1'b0;
    rej_next   = 1'b0;
    rnsec_next = rnsec_reg;
    // Filter writes count only when not bypassed and in its space
    fw_next    = filt_wr_in & cfg_reg[scg_pkg::FILT_B]
               & ({20'h0_0000, filt_addr_in} < scg_pkg::FILT_SPACE);
    case (st_reg)
      scg_pkg::SCG_IDLE: begin
        if (req_in) begin
          // Current decode bits judge each new request
          if (allow0 && allow1) begin
            st_next    = scg_pkg::SCG_ACCESS;
            pass_next  = 1'b1;
            rnsec_next = eff_nsec;
          end else begin
            st_next  = scg_pkg::SCG_ERR;
            rej_next = 1'b1;
          end
        end
      end
      scg_pkg::SCG_ACCESS: st_next = scg_pkg::SCG_IDLE;
      scg_pkg::SCG_ERR:    st_next = scg_pkg::SCG_IDLE;
      default:             st_next = scg_pkg::SCG_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_reg    <= scg_pkg::SCG_IDLE;
      pass_reg  <= 1'b0;
      rej_reg   <= 1'b0;
      rnsec_reg <= 1'b0;
      fw_reg    <= 1'b0;
    end else begin
      st_reg    <= st_next;
      pass_reg  <= pass_next;
      rej_reg   <= rej_next;
      rnsec_reg <= rnsec_next;
      fw_reg    <= fw_next;
    end
  end

  // ----------------------------------------------------------------
  // Static outputs, registered
  // ----------------------------------------------------------------
  logic [3:0] pbd_reg;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) pbd_reg <= 4'h0;
    else          pbd_reg <= {cfg_reg[scg_pkg::PB_HI:scg_pkg::PB_LO], pb0_s2_reg};
  end

  assign prdata_out   = rd_reg;
  assign pready_out   = rdy_reg;
  assign pslverr_out  = err_reg;
  assign req_pass_out = pass_reg;
  assign req_err_out  = rej_reg;
  assign req_nsec_out = rnsec_reg;
  assign filt_wr_out  = fw_reg;
  assign cluster_number_out       = cfg_reg[scg_pkg::CL_HI:scg_pkg::CL_LO];
  assign l2_big_endian_select_out = cfg_reg[scg_pkg::BIGEND_B];
  assign l2_cache_enable_out      = cfg_reg[scg_pkg::L2EN_B];
  assign secure_invasive_debug_en_out = cfg_reg[scg_pkg::SECURE_INVASIVE_DEBUG_EN_B];
  assign noninvasive_debug_en_out     = cfg_reg[scg_pkg::NONINVASIVE_DEBUG_EN_B];
  assign invasive_debug_en_out        = cfg_reg[scg_pkg::INVASIVE_DEBUG_EN_B];
  assign memclk_pll_c_divider_out = cfg_reg[scg_pkg::PC_HI:scg_pkg::PC_LO];
  assign memclk_pll_b_divider_out = pbd_reg;
  assign filter_active_out  = cfg_reg[scg_pkg::FILT_B];
  assign dec0_out           = d0_reg;
  assign dec1_out           = d1_reg;
  assign ext_force_nsec_out = d2_reg;
  // Trace control unsupported
  logic tc_reg;
  always_ff @(posedge clk_in) tc_reg <= 1'b0;
  assign trace_control_pin_out = tc_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  rsvd_read_zero_a: assert property (rdy_reg |-> !rd_reg[31] && !rd_reg[27])
    else $error("reserved bit read nonzero");
  cluster_map_a: assert property (wr_go && hit_cfg1 |=>
    cluster_number_out == $past(pwdata_in[scg_pkg::CL_HI:scg_pkg::CL_LO]))
    else $error("cluster number mismatch");
  nsec_dec_hold_a: assert property (wr_go && ns && hit_d0 |=> $stable(d0_reg))
    else $error("non-secure write changed decode");
  nsec_read_zero_a: assert property (psel_in && penable_in && !rdy_reg && !pwrite_in
    && ns && hit_d0 |=> rd_reg == 32'h0000_0000)
    else $error("non-secure decode read not zero");
  refuse_err_a: assert property (st_reg == scg_pkg::SCG_IDLE && req_in && !(allow0 && allow1)
    |=> req_err_out && !req_pass_out)
    else $error("refused access not errored");
  secure_pass_a: assert property (st_reg == scg_pkg::SCG_IDLE && req_in && !eff_nsec
    |=> req_pass_out)
    else $error("secure access blocked");
  open_pass_a: assert property (st_reg == scg_pkg::SCG_IDLE && req_in && req_sel0_in == 16'h0001
    && d0_reg[0] && req_sel1_in == 16'h0000 |=> req_pass_out)
    else $error("open port refused");
  override_a: assert property (st_reg == scg_pkg::SCG_IDLE && req_in && allow0 && allow1
    && req_ext_in && d2_reg |=> req_nsec_out)
    else $error("override not applied");
  filt_bypass_a: assert property (!cfg_reg[scg_pkg::FILT_B] |=> !filt_wr_out)
    else $error("filter write while bypassed");
  trace_low_a: assert property (##1 !trace_control_pin_out)
    else $error("trace control high");

  pass_c: cover property (req_in ##1 req_pass_out);
  err_c:  cover property (req_in ##1 req_err_out);
  cfgw_c: cover property (wr_go && hit_cfg1);
  fw_c:   cover property (filt_wr_out);

endmodule : scg_top

/* File: design/scg_pkg.sv */
// Purpose: Shared constants for the security and configuration gating block
// Assumes: APB-style register port, word offsets as byte addresses
// Notes:   Decode word layouts and configuration word fields
package scg_pkg;

  // ----------------------------------------------------------------
  // Configuration controller offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CFG_ONE = 12'h0004;
  localparam logic [11:0] OFF_CFG_TWO = 12'h0008;
  localparam logic [31:0] CFG_ONE_RESET = 32'h0000_1F09;
  localparam logic [31:0] CFG_TWO_RESET = 32'h0000_0000;
  // Writable bits of word one (reserved 31 and 27 excluded)
  localparam logic [31:0] CFG_ONE_WMASK = 32'h7780_377F;
  localparam logic [31:0] CFG_TWO_WMASK = 32'hFFFF_FFF8;
  // Reserved bits of word one, always read as zero
  localparam logic [31:0] CFG_ONE_RSVD  = 32'h8800_0000;
  // No bit carries the low divider bit in the first word
  localparam logic [31:0] CFG_ZERO_PB0 = 32'h0000_0000;

  localparam int CL_HI    = 26;
  localparam int CL_LO    = 23;
  localparam int BIGEND_B = 22;
  localparam int FILT_B   = 13;
  localparam int L2EN_B   = 12;
  localparam int SECURE_INVASIVE_DEBUG_EN_B = 10;
  localparam int NONINVASIVE_DEBUG_EN_B  = 9;
  localparam int INVASIVE_DEBUG_EN_B  = 8;
  localparam int PC_HI    = 6;
  localparam int PC_LO    = 3;
  localparam int PB_HI    = 2;
  localparam int PB_LO    = 0;

  // ----------------------------------------------------------------
  // Protection controller offsets and decode bits
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_DEC0 = 12'h0800;
  localparam logic [11:0] OFF_DEC1 = 12'h0804;
  localparam logic [11:0] OFF_DEC2 = 12'h0808;
  localparam logic [15:0] DEC0_USED = 16'h6637;
  localparam logic [15:0] DEC1_USED = 16'h037B;
  localparam logic [15:0] DEC2_USED = 16'h0001;
  localparam logic [15:0] DEC_RESET = 16'h0000;
  localparam int DEC0_SELF_B = 6;

  // Number of peripheral ports for the protected slave selector
  localparam int NPORT = 16;
  localparam logic [31:0] FILT_SPACE = 32'h0000_1000;

  typedef enum logic [1:0] {
    SCG_IDLE,
    SCG_ACCESS,
    SCG_ERR
  } scg_state_e;

endpackage : scg_pkg

/* File: design/scg_gate.sv */
// Purpose: Per-port secure admission check
// Assumes: Decode bit is current register value
// Notes:   Pure compare, registered by the caller
`timescale 1ns/1ps
module scg_gate #(
  parameter int N = 16
) (
  input  wire logic [N-1:0] open_in,   // Decode bits
  input  wire logic [N-1:0] sel_in,    // One-hot target port
  input  wire logic         nsec_in,   // Non-secure access
  output logic              allow_out  // Access admitted
);
  logic [N-1:0] ok;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_port
      // 0 secure only, 1 any
      assign ok[g] = ~sel_in[g] | ~nsec_in | open_in[g];
    end
  endgenerate
  assign allow_out = &ok;
endmodule : scg_gate

/* File: test/scg_master_model.sv */
// Purpose: Bus master model for register accesses and peripheral requests
// Assumes: One clock; requests change 1 ns after the rising edge
// Notes:   Released address, data and selects show the inverse of the last value
`timescale 1ns/1ps
module scg_master_model (
  input  wire logic        clk_in,       // Clock
  input  wire logic [31:0] prdata_in,    // Read data
  input  wire logic        pready_in,    // Access done
  input  wire logic        pslverr_in,   // Error answer
  input  wire logic        pass_in,      // Request forwarded
  input  wire logic        err_in,       // Request refused
  output logic             psel_out,     // Register select
  output logic             penable_out,  // Access phase
  output logic             pwrite_out,   // Write
  output logic             pprot1_out,   // Non-secure
  output logic [11:0]      paddr_out,    // Byte address
  output logic [31:0]      pwdata_out,   // Write data
  output logic             req_out,      // Request
  output logic             req_nsec_out, // Request non-secure
  output logic             req_ext_out,  // External master
  output logic [15:0]      sel0_out,     // APB target
  output logic [15:0]      sel1_out      // AXI target
);
  initial begin
    {psel_out, penable_out, pwrite_out, pprot1_out, req_out, req_nsec_out} = 6'h00;
    {paddr_out, pwdata_out, req_ext_out, sel0_out, sel1_out} = '0;
  end

  // -------------------------------------------------------------
  // Register access, gap sets how slowly the master starts
  // -------------------------------------------------------------
  task automatic apb(input logic wr, input logic ns, input logic [11:0] a,
                     input logic [31:0] d, input int gap,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    #1;
    psel_out    = 1'b1;
    pwrite_out  = wr;
    pprot1_out  = ns;
    paddr_out   = a;
    pwdata_out  = d;
    @(posedge clk_in);
    #1;
    penable_out = 1'b1;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (pready_in !== 1'b1 && n < 16);
    rd = prdata_in;
    er = (pready_in === 1'b1) ? pslverr_in : 1'b1;
    // Hold everything through the edge that samples the answer
    @(posedge clk_in);
    #1;
    psel_out    = 1'b0;
    penable_out = 1'b0;
    paddr_out   = ~paddr_out;
    pwdata_out  = ~pwdata_out;
  endtask : apb

  task automatic req(input logic ns, input logic ext, input logic [15:0] s0,
                     input logic [15:0] s1, output logic p, output logic e);
    @(posedge clk_in);
    #1;
    req_out      = 1'b1;
    req_nsec_out = ns;
    req_ext_out  = ext;
    sel0_out     = s0;
    sel1_out     = s1;
    @(posedge clk_in);
    #1;
    p            = pass_in;
    e            = err_in;
    req_out      = 1'b0;
    req_nsec_out = ~ns;
    sel0_out     = ~s0;
    sel1_out     = ~s1;
  endtask : req
endmodule : scg_master_model

/* File: test/tb_scg_top.sv */
// Purpose: Self-checking bench for the security and configuration gating block
// Assumes: Master model drives register port and requests
// Notes:   Bench inputs change 1 ns after the rising clock edge
`timescale 1ns/1ps
`define SCG_CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s exp=%0h got=%0h", nm, e, g); end end
module tb_scg_top;
  localparam logic [31:0] M  = scg_pkg::CFG_ONE_WMASK;
  localparam logic [31:0] R  = scg_pkg::CFG_ONE_RESET;
  localparam logic [15:0] U0 = scg_pkg::DEC0_USED;
  localparam logic [15:0] U1 = scg_pkg::DEC1_USED;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        pb0 = 1'b1;
  logic        filt_wr = 1'b0;
  logic [11:0] filt_addr = 12'h000;
  logic        psel, penable, pwrite, pprot1, req, req_nsec, req_ext, pready, pslverr;
  logic        pass, err, nsec_o, filt_o, bigend, l2en, secure_invasive_debug_en, noninvasive_debug_en, invasive_debug_en, filt_act;
  logic        extf, trace, ex;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dv;
  logic [15:0] sel0, sel1, dec0, dec1;
  logic [3:0]  cluster, pc, pb;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          i, d;
  logic [31:0] pat [4] = '{32'hFFFF_FFFF, 32'h0000_0000, 32'h5A5A_A5A5, 32'hA5A5_5A5A};

  always #50 clk_in = ~clk_in;

  scg_top #(.NPORT(16)) u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pprot1_in(pprot1), .paddr_in(paddr),
    .pwdata_in(pwdata), .cfg_one_pb0_in(pb0), .req_in(req), .req_nsec_in(req_nsec),
    .req_ext_in(req_ext), .req_sel0_in(sel0), .req_sel1_in(sel1), .filt_wr_in(filt_wr),
    .filt_addr_in(filt_addr), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .req_pass_out(pass), .req_err_out(err), .req_nsec_out(nsec_o),
    .filt_wr_out(filt_o), .cluster_number_out(cluster), .l2_big_endian_select_out(bigend),
    .l2_cache_enable_out(l2en), .secure_invasive_debug_en_out(secure_invasive_debug_en),
    .noninvasive_debug_en_out(noninvasive_debug_en), .invasive_debug_en_out(invasive_debug_en),
    .memclk_pll_c_divider_out(pc), .memclk_pll_b_divider_out(pb),
    .filter_active_out(filt_act), .dec0_out(dec0), .dec1_out(dec1),
    .ext_force_nsec_out(extf), .trace_control_pin_out(trace));

  scg_master_model u_mst (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .pass_in(pass), .err_in(err), .psel_out(psel),
    .penable_out(penable), .pwrite_out(pwrite), .pprot1_out(pprot1), .paddr_out(paddr),
    .pwdata_out(pwdata), .req_out(req), .req_nsec_out(req_nsec), .req_ext_out(req_ext),
    .sel0_out(sel0), .sel1_out(sel1));

  // -------------------------------------------------------------
  // Access and check tasks
  // -------------------------------------------------------------
  task automatic summarize();
    $display("Checks made: %0d, mismatches: %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic ns, input logic [11:0] a, input logic [31:0] v,
                    input logic ee);
    logic [31:0] rd;
    logic        er;
    u_mst.apb(1'b1, ns, a, v, 0, rd, er);
    `SCG_CHK("write_response", ee, er)
  endtask : wr

  task automatic rdc(input logic ns, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] rd;
    logic        er;
    u_mst.apb(1'b0, ns, a, 32'h0000_0000, 1, rd, er);
    `SCG_CHK("read_data", e, rd)
  endtask : rdc

  task automatic reqc(input logic ns, input logic ext, input logic [15:0] s0,
                      input logic [15:0] s1, input logic e);
    logic p, r;
    u_mst.req(ns, ext, s0, s1, p, r);
    `SCG_CHK("req_pass", e, p)
    `SCG_CHK("req_err", !e, r)
  endtask : reqc

  // Fields of word one at the pins, then a filter write at the top of its space
  task automatic check_outs(input logic [31:0] w, input logic b0);
    `SCG_CHK("cluster", w[26:23], cluster)
    `SCG_CHK("big_endian", w[22], bigend)
    `SCG_CHK("l2_enable", w[12], l2en)
    `SCG_CHK("debug_en", w[10:8], {secure_invasive_debug_en, noninvasive_debug_en, invasive_debug_en})
    `SCG_CHK("pll_c", w[6:3], pc)
    `SCG_CHK("pll_b", {w[2:0], b0}, pb)
    `SCG_CHK("filter_on", w[13], filt_act)
    @(posedge clk_in);
    #1;
    filt_wr   = 1'b1;
    filt_addr = 12'hFFC;
    @(posedge clk_in);
    #1;
    filt_wr   = 1'b0;
    filt_addr = 12'h003;
    `SCG_CHK("filter_write", w[13], filt_o)
  endtask : check_outs

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    repeat (20) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    rdc(1'b0, scg_pkg::OFF_CFG_ONE, R);
    check_outs(R, 1'b1);
    `SCG_CHK("trace_ctl", 1'b0, trace)
    `SCG_CHK("dec_reset", 33'h0_0000_0000, {dec0, dec1, extf})
    rdc(1'b0, scg_pkg::OFF_DEC0, 32'h0000_0000);
    rdc(1'b0, scg_pkg::OFF_DEC2, 32'h0000_0000);
    wr(1'b0, scg_pkg::OFF_CFG_TWO, 32'hFFFF_FFFF, 1'b0);
    rdc(1'b0, scg_pkg::OFF_CFG_TWO, 32'h0000_0000);
    wr(1'b0, 12'h00C, 32'h1234_5678, 1'b1);
    rdc(1'b0, 12'h00C, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      pb0 = i[0];
      wr(1'b0, scg_pkg::OFF_CFG_ONE, pat[i], 1'b0);
      rdc(1'b0, scg_pkg::OFF_CFG_ONE, (pat[i] & M) | (R & ~M));
      check_outs((pat[i] & M) | (R & ~M), i[0]);
    end
    // Non-secure software may neither change nor see the decode words
    wr(1'b1, scg_pkg::OFF_DEC0, 32'h0000_FFFF, 1'b0);
    rdc(1'b0, scg_pkg::OFF_DEC0, 32'h0000_0000);
    wr(1'b0, scg_pkg::OFF_DEC0, {16'h0000, U0}, 1'b0);
    rdc(1'b1, scg_pkg::OFF_DEC0, 32'h0000_0000);
    rdc(1'b0, scg_pkg::OFF_DEC0, {16'h0000, U0});
    `SCG_CHK("dec0_out", U0, dec0)
    for (d = 0; d < 2; d++) begin
      dv = (d == 1) ? 32'h0000_FFFF : 32'h0000_0000;
      wr(1'b0, scg_pkg::OFF_DEC0, dv, 1'b0);
      wr(1'b0, scg_pkg::OFF_DEC1, dv, 1'b0);
      for (i = 0; i < 16; i++) begin
        ex = (d == 1) && (i != 6);
        if (U0[i] || i == 6) begin
          reqc(1'b0, 1'b0, 16'h0001 << i, 16'h0000, 1'b1);
          reqc(1'b1, 1'b0, 16'h0001 << i, 16'h0000, ex);
        end
        if (U1[i]) begin
          reqc(1'b0, 1'b0, 16'h0000, 16'h0001 << i, 1'b1);
          reqc(1'b1, 1'b0, 16'h0000, 16'h0001 << i, d == 1);
        end
      end
    end
    wr(1'b0, scg_pkg::OFF_DEC2, 32'h0000_0001, 1'b0);
    rdc(1'b0, scg_pkg::OFF_DEC2, 32'h0000_0001);
    `SCG_CHK("ext_force", 1'b1, extf)
    reqc(1'b0, 1'b1, 16'h0000, 16'h0001, 1'b1);
    `SCG_CHK("fwd_nsec", 1'b1, nsec_o)
    wr(1'b0, scg_pkg::OFF_DEC1, 32'h0000_0000, 1'b0);
    reqc(1'b0, 1'b1, 16'h0000, 16'h0001, 1'b0);
    wr(1'b0, scg_pkg::OFF_DEC2, 32'h0000_0000, 1'b0);
    reqc(1'b0, 1'b1, 16'h0000, 16'h0001, 1'b1);
    `SCG_CHK("fwd_sec", 1'b0, nsec_o)
    // Second reset in mid-run must reopen nothing
    nrst_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    `SCG_CHK("dec_rereset", 33'h0_0000_0000, {dec0, dec1, extf})
    summarize();
  end
endmodule : tb_scg_top
